// *** verilog/dds_ctrl_cfg.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef DDS_CTRL_CFG_SVH
`define DDS_CTRL_CFG_SVH

`define REG_PHASE1_HI 6'h00
`define REG_PHASE1_LO 6'h01
`define REG_PHASE2_HI 6'h02
`define REG_PHASE2_LO 6'h03
`define REG_FREQ1_B5 6'h04
`define REG_FREQ1_B0 6'h09
`define REG_INTERVAL_B3 6'h16
`define REG_INTERVAL_B2 6'h17
`define REG_INTERVAL_B1 6'h18
`define REG_INTERVAL_B0 6'h19
`define REG_POWER 6'h1d
`define REG_CONTROL 6'h1f
`define REG_SHAPE 6'h20
`define REG_AMP_I_HI 6'h21
`define REG_AMP_I_LO 6'h22
`define REG_AMP_Q_HI 6'h23
`define REG_AMP_Q_LO 6'h24
`define REG_RAMP_RATE 6'h25
`define REG_LAST 6'h25
`define REG_COUNT 38

`define BIT_CONVERTER_PD 2
`define BIT_INTERNAL_STROBE 0
`define MODE_LSB 1
`define MODE_MSB 3
`define BIT_SHAPING_EN 5
`define BIT_INTERNAL_RAMP 4

`define RESET_BYTE 8'h00
`define RESET_CONTROL 8'h01

`define STROBE_HIGH_CYCLES 4'h8
`define STROBE_MIN_INTERVAL 32'h0000_0005
`define RAMP_MIN_COUNT 8'h03
`define STEP_FULL 12'hfff
`define STEP_ZERO 12'h000

`endif

// *** verilog/dds_ctrl_pkg.sv ***
// Types shared by the update and keying control modules
package dds_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [11:0] amp_t;
  typedef enum logic [2:0] {
    MODE_SINGLE_TONE = 3'h0,
    MODE_FSK = 3'h1,
    MODE_RAMPED_FSK = 3'h2,
    MODE_CHIRP = 3'h3,
    MODE_BPSK = 3'h4
  } synth_mode_e;
  typedef enum logic [1:0] {
    CNT_IDLE = 2'b01,
    CNT_RUN = 2'b10
  } count_state_e;
endpackage : dds_ctrl_pkg

// *** verilog/strobe_gen.sv ***
// Internal transfer strobe: half-rate 32-bit down-counter and pin pulse
`timescale 1ns/1ps
`include "dds_ctrl_cfg.svh"
module strobe_gen
  import dds_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [31:0] interval,
  output logic strobe_pulse,
  output logic pin_level
);
  count_state_e state_r, state_nxt;
  logic half_r, half_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic [3:0] high_r, high_nxt;

  // Counter only moves on every second clock, giving the half-rate tick
  always_comb begin
    state_nxt = state_r;
    half_nxt = enable ? ~half_r : 1'b0;
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    high_nxt = (high_r != 4'h0) ? high_r - 4'h1 : 4'h0;
    case (state_r)
      CNT_IDLE: begin
        if (enable) begin
          cnt_nxt = interval;
          state_nxt = CNT_RUN;
        end
      end
      CNT_RUN: begin
        if (!enable) begin
          state_nxt = CNT_IDLE;
        end else if (half_r) begin
          if (cnt_r == 32'h0) begin
            pulse_nxt = 1'b1; // [RULE7]
            cnt_nxt = interval; // [RULE8]
          end else begin
            cnt_nxt = cnt_r - 32'h1; // [RULE7]
          end
        end
      end
      default: state_nxt = CNT_IDLE;
    endcase
    if (pulse_r) begin
      high_nxt = `STROBE_HIGH_CYCLES - 4'h1; // [RULE9]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CNT_IDLE;
      half_r <= 1'b0;
      cnt_r <= 32'h0;
      pulse_r <= 1'b0;
      high_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      half_r <= half_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
      high_r <= high_nxt;
    end
  end

  assign strobe_pulse = pulse_r;
  // Short intervals would overlap the fixed high time, so the pin sits high
  assign pin_level = (interval < `STROBE_MIN_INTERVAL) ? 1'b1 : // [RULE10]
                     (pulse_r || (high_r != 4'h0)); // [RULE9]
endmodule : strobe_gen

// *** verilog/envelope_ramp.sv ***
// Linear envelope: 8-bit ramp rate counter driving a 12-bit step counter
`timescale 1ns/1ps
`include "dds_ctrl_cfg.svh"
module envelope_ramp
  import dds_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] rate,
  input wire logic ramp_up,
  output amp_t step
);
  count_state_e state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  amp_t step_r, step_nxt;
  logic tick;

  // Load edge, then N decrements, gives a pulse every N+1 clocks
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    tick = 1'b0;
    if (rate < `RAMP_MIN_COUNT) begin
      state_nxt = CNT_IDLE; // [RULE16]
    end else begin
      case (state_r)
        CNT_IDLE: begin
          cnt_nxt = rate; // [RULE15]
          state_nxt = CNT_RUN;
        end
        CNT_RUN: begin
          if (cnt_r == 8'h0) begin
            tick = 1'b1; // [RULE13]
            cnt_nxt = rate; // [RULE17]
          end else begin
            cnt_nxt = cnt_r - 8'h1; // [RULE15]
          end
        end
        default: state_nxt = CNT_IDLE;
      endcase
    end
    // Saturate at both ends so a held level never wraps the envelope
    if (tick) begin
      if (ramp_up && step_r != `STEP_FULL) begin
        step_nxt = step_r + 12'h1; // [RULE18] [RULE22]
      end else if (!ramp_up && step_r != `STEP_ZERO) begin
        step_nxt = step_r - 12'h1; // [RULE18] [RULE22]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= CNT_IDLE;
      cnt_r <= 8'h0;
      step_r <= `STEP_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
    end
  end

  assign step = step_r;
endmodule : envelope_ramp

// *** verilog/dds_update_and_keying_ctrl.sv ***
// Update strobe, phase keying and amplitude keying control of the DDS
//
// Contract
// [RULE1] Keying pin low picks phase one, high two
// [RULE2] Host loads words, attaches keying, then strobes
// [RULE3] Program words move only on strobe rising edge
// [RULE4] External strobe resynchronised to the system clock
// [RULE5] Strobe source bit resets high, internal
// [RULE6] Interval spans four bytes, source bit in control
// [RULE7] Interval counter decrements at half rate, zero transfers
// [RULE8] Strobe spacing is (N+1) times two clocks
// [RULE9] Internal strobe drives pin high eight clocks
// [RULE10] Interval below five keeps pin high
// [RULE11] Shaping disabled bypasses multipliers, full scale
// [RULE12] Ramp select picks internal ramp or manual words
// [RULE13] Rate counter zero pulse advances step counter
// [RULE14] Multiplier code scales amplitude by code over 4096
// [RULE15] First edge loads rate counter, next decrements
// [RULE16] Rate value below three stalls the ramp
// [RULE17] Ramp pulses every N+1 clocks, 4096 steps
// [RULE18] Envelope pin high ramps up, low ramps down
// [RULE19] Power-down bit turns off both converters
// [RULE20] Sine feeds Q path, cosine feeds I path
// [RULE21] Host rewrites phase one for higher-order keying
// [RULE22] Step counter saturates at both ends
`timescale 1ns/1ps
`include "dds_ctrl_cfg.svh"
module dds_update_and_keying_ctrl
  import dds_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic prog_wr_en,
  input wire logic [5:0] prog_wr_addr,
  input wire logic [7:0] prog_wr_data,
  input wire logic [5:0] prog_rd_addr,
  output logic [7:0] prog_rd_data,
  input wire logic strobe_pin_i,
  output logic strobe_pin_o,
  output logic strobe_pin_oe,
  input wire logic phase_key_pin,
  input wire logic keyed_envelope_pin,
  input wire logic [11:0] sine_word,
  input wire logic [11:0] cosine_word,
  output logic [11:0] i_dac_data,
  output logic [11:0] q_dac_data,
  output logic converter_powerdown,
  output logic [13:0] phase_offset_word,
  output logic [47:0] start_frequency_word,
  output logic [2:0] synth_mode,
  output logic transfer_pulse
);
  // Buffered program bytes written by the host, and the active copy
  byte_t buf_r [0:`REG_COUNT-1];
  byte_t act_r [0:`REG_COUNT-1];
  byte_t rd_r, rd_nxt;

  // External strobe synchroniser and edge detector
  logic ext_sync1_r, ext_sync2_r, ext_prev_r;
  logic ext_sync1_nxt, ext_sync2_nxt, ext_prev_nxt;
  logic ext_edge;

  // Registered datapath outputs
  logic [11:0] i_out_r, i_out_nxt;
  logic [11:0] q_out_r, q_out_nxt;
  logic [13:0] phase_r, phase_nxt;

  logic internal_strobe;
  logic gen_pulse;
  logic gen_level;
  logic transfer;
  logic [31:0] interval;
  logic shaping_en;
  logic internal_ramp;
  logic powerdown;
  amp_t ramp_step;
  amp_t amp_i;
  amp_t amp_q;
  synth_mode_e mode;

  // Reset value of one program byte; control byte selects internal strobe
  function automatic byte_t reset_value(input int idx);
    if (idx == int'(`REG_CONTROL)) begin
      reset_value = `RESET_CONTROL; // [RULE5]
    end else begin
      reset_value = `RESET_BYTE;
    end
  endfunction : reset_value

  // Scales a signed sample by code/4096; all ones gives 4095/4096
  function automatic logic [11:0] scale(input logic [11:0] sample,
                                        input amp_t code);
    logic signed [24:0] prod;
    prod = 25'(signed'(sample)) * 25'(signed'({1'b0, code}));
    scale = prod[23:12]; // [RULE14]
  endfunction : scale

  // Joins a high and low byte pair into a 12-bit amplitude word
  function automatic amp_t amp_word(input byte_t hi, input byte_t lo);
    amp_word = {hi[3:0], lo};
  endfunction : amp_word

  // Decoded fields of the active program bytes
  assign internal_strobe = act_r[`REG_CONTROL][`BIT_INTERNAL_STROBE]; // [RULE5]
  assign interval = {act_r[`REG_INTERVAL_B3], act_r[`REG_INTERVAL_B2],
                     act_r[`REG_INTERVAL_B1],
                     act_r[`REG_INTERVAL_B0]}; // [RULE6]
  assign mode = synth_mode_e'(act_r[`REG_CONTROL][`MODE_MSB:`MODE_LSB]);
  assign shaping_en = act_r[`REG_SHAPE][`BIT_SHAPING_EN];
  assign internal_ramp = act_r[`REG_SHAPE][`BIT_INTERNAL_RAMP];
  assign powerdown = act_r[`REG_POWER][`BIT_CONVERTER_PD];

  strobe_gen u_strobe_gen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(internal_strobe),
    .interval(interval),
    .strobe_pulse(gen_pulse),
    .pin_level(gen_level)
  );

  envelope_ramp u_envelope_ramp (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .rate(act_r[`REG_RAMP_RATE]),
    .ramp_up(keyed_envelope_pin),
    .step(ramp_step)
  );

  // Two flops before the edge detector keep a late strobe from splitting
  // the transfer across cycles
  always_comb begin
    ext_sync1_nxt = strobe_pin_i; // [RULE4]
    ext_sync2_nxt = ext_sync1_r; // [RULE4]
    ext_prev_nxt = ext_sync2_r;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync1_r <= 1'b0;
      ext_sync2_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync1_r <= ext_sync1_nxt;
      ext_sync2_r <= ext_sync2_nxt;
      ext_prev_r <= ext_prev_nxt;
    end
  end

  assign ext_edge = ext_sync2_r && !ext_prev_r; // [RULE3]
  assign transfer = internal_strobe ? gen_pulse : ext_edge; // [RULE3]

  // Host writes land in the buffer; the active copy follows only on a
  // transfer, so with the external strobe half-written multi-byte words never reach the core
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < `REG_COUNT; k++) begin
        buf_r[k] <= reset_value(k);
        act_r[k] <= reset_value(k);
      end
    end else begin
      if (prog_wr_en && prog_wr_addr <= `REG_LAST) begin
        buf_r[prog_wr_addr] <= prog_wr_data;
      end
      if (transfer) begin
        for (int k = 0; k < `REG_COUNT; k++) begin
          act_r[k] <= buf_r[k]; // [RULE3]
        end
      end
    end
  end

  // Read-back of the buffered bytes; unmapped addresses read zero
  always_comb begin
    rd_nxt = 8'h00;
    if (prog_rd_addr <= `REG_LAST) begin
      rd_nxt = buf_r[prog_rd_addr];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // Amplitude codes: internal ramp feeds both paths, else manual words
  always_comb begin
    if (internal_ramp) begin
      amp_i = ramp_step; // [RULE12] [RULE13]
      amp_q = ramp_step; // [RULE12]
    end else begin
      amp_i = amp_word(act_r[`REG_AMP_I_HI], act_r[`REG_AMP_I_LO]); // [RULE12]
      amp_q = amp_word(act_r[`REG_AMP_Q_HI], act_r[`REG_AMP_Q_LO]); // [RULE12]
    end
  end

  // Converter words: cosine to I, sine to Q, gated by power-down
  always_comb begin
    if (powerdown) begin
      i_out_nxt = 12'h000; // [RULE19]
      q_out_nxt = 12'h000; // [RULE19]
    end else if (!shaping_en) begin
      i_out_nxt = cosine_word; // [RULE11] [RULE20]
      q_out_nxt = sine_word; // [RULE11] [RULE20]
    end else begin
      i_out_nxt = scale(cosine_word, amp_i); // [RULE11] [RULE20]
      q_out_nxt = scale(sine_word, amp_q); // [RULE11] [RULE20]
    end
  end

  // Phase offset: both paths share one word, keyed only in phase mode
  always_comb begin
    phase_nxt = {act_r[`REG_PHASE1_HI][5:0], act_r[`REG_PHASE1_LO]};
    if (mode == MODE_BPSK && phase_key_pin) begin
      phase_nxt = {act_r[`REG_PHASE2_HI][5:0],
                   act_r[`REG_PHASE2_LO]}; // [RULE1]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      i_out_r <= 12'h000;
      q_out_r <= 12'h000;
      phase_r <= 14'h0000;
    end else begin
      i_out_r <= i_out_nxt;
      q_out_r <= q_out_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign prog_rd_data = rd_r;
  assign i_dac_data = i_out_r;
  assign q_dac_data = q_out_r;
  assign phase_offset_word = phase_r;
  assign converter_powerdown = powerdown; // [RULE19]
  assign start_frequency_word = {act_r[`REG_FREQ1_B5], act_r[5'd5],
                                 act_r[5'd6], act_r[5'd7], act_r[5'd8],
                                 act_r[`REG_FREQ1_B0]};
  assign synth_mode = mode;
  assign transfer_pulse = transfer;
  // Pin is driven only while the strobe is generated internally
  assign strobe_pin_oe = internal_strobe; // [RULE9]
  assign strobe_pin_o = internal_strobe ? gen_level : 1'b0; // [RULE9]
endmodule : dds_update_and_keying_ctrl

// *** test/dds_ctrl_asserts.sv ***
// Port-level checker for the update and keying control block
`timescale 1ns/1ps
module dds_ctrl_asserts
  import dds_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic strobe_pin_i,
  input wire logic strobe_pin_o,
  input wire logic strobe_pin_oe,
  input wire logic phase_key_pin,
  input wire logic [11:0] i_dac_data,
  input wire logic [11:0] q_dac_data,
  input wire logic converter_powerdown,
  input wire logic [13:0] phase_offset_word,
  input wire logic [47:0] start_frequency_word,
  input wire logic [2:0] synth_mode,
  input wire logic transfer_pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Pin pulse timing of the internal strobe
  a_pin_high_eight: assert property ($rose(strobe_pin_o) |->
    strobe_pin_o [*8]) else $error("strobe pin high time short");
  a_rise_marks_pulse: assert property (($rose(strobe_pin_o) &&
    $past(strobe_pin_oe) && !$past(transfer_pulse)) |-> transfer_pulse)
    else $error("strobe pin rise without transfer");
  a_pulse_single: assert property (transfer_pulse |=>
    !transfer_pulse) else $error("transfer pulse too long");
  // Two sync flops plus edge detect give a fixed delay
  a_ext_sync_delay: assert property ((!strobe_pin_oe &&
    $rose(strobe_pin_i)) |-> !transfer_pulse [*2] ##1 transfer_pulse)
    else $error("external strobe delay wrong");
  // Active words move only after a transfer; reset strobe source, released pin level and power-down outputs
  a_active_hold: assert property (!transfer_pulse |=>
    $stable(start_frequency_word) && $stable(synth_mode))
    else $error("active word changed without transfer");
  a_ctrl_hold: assert property (!transfer_pulse |=>
    $stable(converter_powerdown) && $stable(strobe_pin_oe))
    else $error("control changed without transfer");
  a_reset_internal: assert property (!$past(reset_n) |->
    strobe_pin_oe) else $error("strobe source not internal");
  a_undriven_low: assert property (!strobe_pin_oe |->
    !strobe_pin_o) else $error("strobe pin level while released");
  a_powerdown_zero: assert property ((converter_powerdown &&
    $past(converter_powerdown)) |-> (i_dac_data == 12'h000 &&
    q_dac_data == 12'h000)) else $error("output while powered down");
  a_phase_hold: assert property ((synth_mode == MODE_BPSK &&
    $stable(phase_key_pin) && !transfer_pulse && !$past(transfer_pulse))
    |=> $stable(phase_offset_word)) else $error("phase moved, key held");

  // Main scenarios reached
  c_int_pulse: cover property (transfer_pulse && strobe_pin_oe);
  c_ext_pulse: cover property (transfer_pulse && !strobe_pin_oe);
  c_bpsk: cover property (synth_mode == MODE_BPSK && phase_key_pin);
  c_pd: cover property (converter_powerdown);
endmodule : dds_ctrl_asserts

bind dds_update_and_keying_ctrl dds_ctrl_asserts i_chk (.sys_clk,
  .reset_n, .strobe_pin_i, .strobe_pin_o, .strobe_pin_oe, .phase_key_pin,
  .i_dac_data, .q_dac_data, .converter_powerdown, .phase_offset_word,
  .start_frequency_word, .synth_mode, .transfer_pulse);

// *** test/host_model.sv ***
// Host controller model: register port, strobe and keying pins
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  input wire logic [7:0] rd_data,
  output logic wr_en,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [5:0] rd_addr,
  output logic strobe,
  output logic phase_key,
  output logic env_key
);
  // Idle levels at time zero
  initial begin
    {wr_en, strobe, phase_key, env_key} = 4'h0;
    {wr_addr, rd_addr, wr_data} = 20'h00000;
  end

  // One byte write; released lines show a changed pattern
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask : wr

  // Read answer lands one cycle after the address edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 d = rd_data;
  endtask : rd

  // Phase one rewrite, also the path for multi-level keying
  task automatic ph1(input logic [13:0] w);
    wr(6'h00, {2'b00, w[13:8]});
    wr(6'h01, w[7:0]);
  endtask : ph1

  // Strobe raised only once the words are loaded
  task automatic stb(input logic s);
    @(posedge sys_clk);
    strobe <= s;
  endtask : stb

  // Keying levels for phase and envelope
  task automatic keys(input logic p, input logic e);
    @(posedge sys_clk);
    phase_key <= p;
    env_key <= e;
  endtask : keys
endmodule : host_model

// *** test/test_dds_update_and_keying_ctrl.sv ***
// Self-checking bench of the update and keying control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_dds_update_and_keying_ctrl
  import dds_ctrl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] sine_word = 12'h000;
  logic [11:0] cosine_word = 12'h000;
  logic wr_en, strobe, phase_key, env_key, strobe_pin_o, strobe_pin_oe;
  logic converter_powerdown, transfer_pulse;
  logic [5:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data, d;
  logic [11:0] i_dac_data, q_dac_data, ai, aq, lv;
  logic [13:0] phase_offset_word, p1, p2;
  logic [47:0] start_frequency_word, f;
  logic [2:0] synth_mode;
  logic [15:0] rnd = 16'h4089;
  int mismatches = 0;
  int n_compared = 0;
  int n, h;
  // Pin level from both drivers; the device wins while enabled
  wire logic pin = strobe_pin_oe ? strobe_pin_o : strobe;

  initial forever #5 sys_clk = ~sys_clk;

  host_model i_host (.sys_clk(sys_clk), .rd_data(rd_data),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .strobe(strobe), .phase_key(phase_key),
    .env_key(env_key));
  dds_update_and_keying_ctrl i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .prog_wr_en(wr_en), .prog_wr_addr(wr_addr), .prog_wr_data(wr_data),
    .prog_rd_addr(rd_addr), .prog_rd_data(rd_data), .strobe_pin_i(pin),
    .strobe_pin_o(strobe_pin_o), .strobe_pin_oe(strobe_pin_oe),
    .phase_key_pin(phase_key), .keyed_envelope_pin(env_key),
    .sine_word(sine_word), .cosine_word(cosine_word),
    .i_dac_data(i_dac_data), .q_dac_data(q_dac_data),
    .converter_powerdown(converter_powerdown),
    .phase_offset_word(phase_offset_word),
    .start_frequency_word(start_frequency_word),
    .synth_mode(synth_mode), .transfer_pulse(transfer_pulse));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Signed sample times code over 4096, floor rounding
  function automatic logic [11:0] scale(input logic [11:0] s,
                                        input logic [11:0] c);
    logic signed [24:0] pr;
    pr = $signed(s) * $signed({1'b0, c});
    return pr[23:12];
  endfunction : scale

  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  // Bounded wait for the next transfer, counting cycles
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      tick();
      c++;
    end while (transfer_pulse !== 1'b1 && c < 1000);
    `CHK("transfer seen", 1'b1, transfer_pulse)
  endtask : wait_pulse
  // External strobe; sync flops plus edge detect cost two cycles
  task automatic upd;
    i_host.stb(1'b1);
    wait_pulse(n);
    `CHK("sync delay", 2, n)
    i_host.stb(1'b0);
    repeat (3) tick();
  endtask : upd
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Watchdog well beyond the 35k cycles the run needs
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset image, unmapped addresses read zero
    i_host.wr(6'h30, 8'h5a);
    for (int a = 0; a < 40; a++) begin
      i_host.rd(a[5:0], d);
      `CHK("reset byte", (a == 'h1f) ? 8'h01 : 8'h00, d)
    end
    for (int a = 0; a < 4; a++) begin
      rnd = lfsr(rnd);
      i_host.wr(a[5:0], rnd[7:0]);
      i_host.rd(a[5:0], d);
      `CHK("read back", rnd[7:0], d)
    end
    $display("test registers done");
    // Internal strobe with N of six, then three
    i_host.wr(6'h19, 8'h06);
    repeat (40) tick();
    wait_pulse(n);
    h = 0;
    while (strobe_pin_o === 1'b1 && h < 20) begin
      h++;
      tick();
    end
    `CHK("pin high", 8, h)
    wait_pulse(n);
    `CHK("period", 14, n + h)
    i_host.wr(6'h19, 8'h03);
    repeat (40) tick();
    h = 0;
    n = 0;
    repeat (40) begin
      tick();
      h += strobe_pin_o;
      n += transfer_pulse;
    end
    `CHK("pin held", 40, h)
    `CHK("pulses", 5, n)
    $display("test internal strobe done");
    // External strobe, phase keying
    i_host.wr(6'h1f, 8'h08);
    repeat (20) tick();
    `CHK("oe", 1'b0, strobe_pin_oe)
    for (int b = 0; b < 6; b++) begin
      rnd = lfsr(rnd);
      f = {f[39:0], rnd[7:0]};
      i_host.wr(6'h04 + b[5:0], rnd[7:0]);
    end
    rnd = lfsr(rnd);
    p1 = rnd[13:0];
    i_host.ph1(p1);
    p2 = ~p1;
    i_host.wr(6'h02, {2'b00, p2[13:8]});
    i_host.wr(6'h03, p2[7:0]);
    `CHK("freq held", 48'h0, start_frequency_word)
    upd();
    `CHK("freq", f, start_frequency_word)
    `CHK("mode", MODE_BPSK, synth_mode)
    for (int k = 0; k < 2; k++) begin
      i_host.keys(k[0], 1'b0);
      repeat (3) tick();
      `CHK("phase", k ? p2 : p1, phase_offset_word)
    end
    $display("test phase keying done");
    // Manual amplitude, bypass and power-down
    i_host.wr(6'h20, 8'h20);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      ai = k ? rnd[11:0] : 12'h000;
      aq = k ? rnd[15:4] : 12'hfff;
      rnd = lfsr(rnd);
      @(posedge sys_clk);
      sine_word <= rnd[11:0];
      cosine_word <= rnd[15:4];
      i_host.wr(6'h21, {4'h0, ai[11:8]});
      i_host.wr(6'h22, ai[7:0]);
      i_host.wr(6'h23, {4'h0, aq[11:8]});
      i_host.wr(6'h24, aq[7:0]);
      upd();
      `CHK("i amp", scale(cosine_word, ai), i_dac_data)
      `CHK("q amp", scale(sine_word, aq), q_dac_data)
    end
    i_host.wr(6'h20, 8'h00);
    upd();
    `CHK("i bypass", cosine_word, i_dac_data)
    `CHK("q bypass", sine_word, q_dac_data)
    i_host.wr(6'h1d, 8'h04);
    upd();
    `CHK("pd", 24'h0, {i_dac_data, q_dac_data})
    i_host.wr(6'h1d, 8'h00);
    upd();
    $display("test amplitude done");
    // Internal ramp up, saturate, ramp down, stall, ramp down to zero
    @(posedge sys_clk);
    sine_word <= 12'h7ff;
    cosine_word <= 12'h800;
    i_host.wr(6'h25, 8'h03);
    i_host.wr(6'h20, 8'h30);
    i_host.keys(1'b0, 1'b1);
    upd();
    repeat (16000) tick();
    `CHK("ramp mid", 1'b1, q_dac_data < 12'h7fe)
    repeat (600) tick();
    `CHK("ramp full", scale(12'h7ff, 12'hfff), q_dac_data)
    repeat (1000) tick();
    `CHK("ramp sat", scale(12'h800, 12'hfff), i_dac_data)
    i_host.keys(1'b0, 1'b0);
    repeat (8000) tick();
    i_host.wr(6'h25, 8'h02);
    upd();
    lv = q_dac_data;
    repeat (100) tick();
    `CHK("stall", lv, q_dac_data)
    i_host.wr(6'h25, 8'h03);
    upd();
    repeat (9000) tick();
    `CHK("ramp zero", 24'h0, {i_dac_data, q_dac_data})
    $display("test ramp done");
    final_report();
  end
endmodule : test_dds_update_and_keying_ctrl
